/* File: core/hbsc_drive_ctrl.sv */
// Top of the half-bridge serial control port: frame check, control register, faults, drivers.
`timescale 1ns/1ps
module hbsc_drive_ctrl #(
	parameter int unsigned UL_DELAY_CYC = hbsc_pkg::UL_DELAY_CYC
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_b_in,
	input  wire logic                    spi_sclk_in,
	input  wire logic                    chip_select_n_in,
	input  wire logic                    serial_data_in,
	output logic                         serial_data_out,
	output logic                         serial_data_oe_out,
	input  wire logic                    overvoltage_in,
	input  wire logic                    undervoltage_lockout_in,
	input  wire logic                    thermal_warning_in,
	input  wire hbsc_pkg::hbsc_drv_t     overcurrent_in,
	input  wire hbsc_pkg::hbsc_drv_t     underload_in,
	output hbsc_pkg::hbsc_drv_t          driver_on_out,
	output logic                         overvoltage_shutdown_enable_out,
	output logic                         underload_shutdown_enable_out,
	output logic                         overcurrent_shutdown_enable_out
);
	localparam int unsigned SYNC_W = 2 * hbsc_pkg::DRV_N + 4;
	localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W - 1){1'b0}}};
	localparam hbsc_pkg::hbsc_ulcnt_t UL_LIMIT = hbsc_pkg::hbsc_ulcnt_t'(UL_DELAY_CYC);
	localparam hbsc_pkg::hbsc_ulcnt_t UL_ZERO  = 14'h0000;
	localparam hbsc_pkg::hbsc_ulcnt_t UL_STEP  = 14'h0001;

	hbsc_link_if lnk ();

	logic [SYNC_W-1:0]      sync_q;
	logic                   cs_n_s;
	logic                   ov_s;
	logic                   uv_s;
	logic                   thermal_warning_s;
	hbsc_pkg::hbsc_drv_t    oc_s;
	hbsc_pkg::hbsc_drv_t    ul_s;

	hbsc_pkg::hbsc_frame_st_t st_ff;
	hbsc_pkg::hbsc_frame_st_t nxt_st;
	hbsc_pkg::hbsc_word_t   ctrl_ff;
	hbsc_pkg::hbsc_word_t   nxt_ctrl;
	hbsc_pkg::hbsc_word_t   snap_ff;
	hbsc_pkg::hbsc_word_t   nxt_snap;
	logic                   frame_ok;
	logic                   apply;
	logic                   clear;

	logic                   supply_fail_flag_ff;
	logic                   nxt_supply_fail_flag;
	logic                   ulf_ff;
	logic                   nxt_ulf;
	logic                   olf_ff;
	logic                   nxt_olf;
	hbsc_pkg::hbsc_drv_t    latch_ff;
	hbsc_pkg::hbsc_drv_t    nxt_latch;
	hbsc_pkg::hbsc_drv_t    drv_ff;
	hbsc_pkg::hbsc_drv_t    nxt_drv;
	hbsc_pkg::hbsc_drv_t    ul_hit;
	hbsc_pkg::hbsc_drv_t    oc_hit;
	hbsc_pkg::hbsc_ulcnt_t  ul_cnt_ff [hbsc_pkg::DRV_N];
	hbsc_pkg::hbsc_ulcnt_t  nxt_ul_cnt [hbsc_pkg::DRV_N];
	logic                   supply_off;
	logic                   ov_shut_en;
	logic                   ul_shut_en;
	logic                   oc_shut_en;
	hbsc_pkg::hbsc_word_t   status_now;

	// Chip select, supply, thermal and driver fault pins pass two flops; the serial clock and data do not. Chip select idles high.
	hbsc_sync #(
		.W     (SYNC_W),
		.RST_V (SYNC_RST)
	) u_sync (
		.clk_in   (sys_clk_in),
		.rst_b_in (rst_b_in),
		.d_in     ({chip_select_n_in, overvoltage_in, undervoltage_lockout_in, thermal_warning_in,
		            overcurrent_in, underload_in}),
		.q_out    (sync_q)
	);

	assign cs_n_s = sync_q[SYNC_W-1];
	assign ov_s   = sync_q[SYNC_W-2];
	assign uv_s   = sync_q[SYNC_W-3];
	assign thermal_warning_s = sync_q[SYNC_W-4];
	assign oc_s   = sync_q[2*hbsc_pkg::DRV_N-1:hbsc_pkg::DRV_N];
	assign ul_s   = sync_q[hbsc_pkg::DRV_N-1:0];

	hbsc_spi_link u_link (
		.spi_sclk_in      (spi_sclk_in),
		.rst_b_in         (rst_b_in),
		.chip_select_n_in (chip_select_n_in),
		.serial_data_in   (serial_data_in),
		.so_data_out      (serial_data_out),
		.lnk              (lnk.link)
	);

	// The output driver follows the pin directly so it lets go within the same instant.
	assign serial_data_oe_out = !chip_select_n_in;

	// Link results are read only after chip select has risen, when the serial clock is idle.
	assign frame_ok = lnk.wrapped && (lnk.edge_cnt == hbsc_pkg::CNT_ZERO);
	assign apply    = (st_ff == hbsc_pkg::HBSC_APPLY) && frame_ok;
	assign clear    = apply && lnk.rx_word[hbsc_pkg::BIT_CLEAR];

	always_comb begin
		nxt_st   = st_ff;
		nxt_ctrl = ctrl_ff;
		nxt_snap = snap_ff;
		case (st_ff)
			hbsc_pkg::HBSC_IDLE: begin
				nxt_snap = status_now;
				if (!cs_n_s) begin
					nxt_st = hbsc_pkg::HBSC_FRAME;
				end
			end
			hbsc_pkg::HBSC_FRAME: begin
				if (cs_n_s) begin
					nxt_st = hbsc_pkg::HBSC_APPLY;
				end
			end
			hbsc_pkg::HBSC_APPLY: begin
				if (frame_ok) begin
					nxt_ctrl = lnk.rx_word;
				end
				nxt_st = hbsc_pkg::HBSC_IDLE;
			end
			default: begin
				nxt_st = hbsc_pkg::HBSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff   <= hbsc_pkg::HBSC_IDLE;
			ctrl_ff <= hbsc_pkg::CTRL_RST;
			snap_ff <= hbsc_pkg::STAT_RST;
		end else begin
			st_ff   <= nxt_st;
			ctrl_ff <= nxt_ctrl;
			snap_ff <= nxt_snap;
		end
	end

	// The snapshot freezes while a frame runs, so the shifted-out word never tears.
	assign lnk.status_word = snap_ff;

	assign ov_shut_en = ctrl_ff[hbsc_pkg::BIT_OV_SHUT_EN];
	assign ul_shut_en = ctrl_ff[hbsc_pkg::BIT_UL_SHUT_EN];
	assign oc_shut_en = ctrl_ff[hbsc_pkg::BIT_OC_SHUT_EN];

	// Overvoltage only forces drivers off; the programmed pattern stays in the control register.
	assign supply_off = (ov_shut_en && ov_s) || uv_s;

	always_comb begin
		for (int i = 0; i < hbsc_pkg::DRV_N; i++) begin
			if (drv_ff[i] && ul_s[i]) begin
				nxt_ul_cnt[i] = (ul_cnt_ff[i] == UL_LIMIT) ? UL_LIMIT : hbsc_pkg::hbsc_ulcnt_t'(ul_cnt_ff[i] + UL_STEP);
			end else begin
				nxt_ul_cnt[i] = UL_ZERO;
			end
			ul_hit[i] = (ul_cnt_ff[i] == UL_LIMIT);
		end
		oc_hit = oc_s & drv_ff;
		// A fault arriving in the cycle of a clear is kept: the set term wins.
		nxt_supply_fail_flag = (supply_fail_flag_ff && !clear) || ov_s || uv_s;
		nxt_ulf   = (ulf_ff && !clear) || (|ul_hit);
		nxt_olf   = (olf_ff && !clear) || (|oc_hit);
		nxt_latch = (clear ? hbsc_pkg::DRV_OFF : latch_ff)
			| (oc_shut_en ? oc_hit : hbsc_pkg::DRV_OFF)
			| (ul_shut_en ? ul_hit : hbsc_pkg::DRV_OFF);
		nxt_drv   = supply_off ? hbsc_pkg::DRV_OFF
			: (ctrl_ff[hbsc_pkg::BIT_DRV_HI:hbsc_pkg::BIT_DRV_LO] & ~latch_ff);
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			supply_fail_flag_ff <= 1'b0;
			ulf_ff   <= 1'b0;
			olf_ff   <= 1'b0;
			latch_ff <= hbsc_pkg::DRV_OFF;
			drv_ff   <= hbsc_pkg::DRV_OFF;
			for (int i = 0; i < hbsc_pkg::DRV_N; i++) begin
				ul_cnt_ff[i] <= UL_ZERO;
			end
		end else begin
			supply_fail_flag_ff <= nxt_supply_fail_flag;
			ulf_ff   <= nxt_ulf;
			olf_ff   <= nxt_olf;
			latch_ff <= nxt_latch;
			drv_ff   <= nxt_drv;
			for (int i = 0; i < hbsc_pkg::DRV_N; i++) begin
				ul_cnt_ff[i] <= nxt_ul_cnt[i];
			end
		end
	end

	assign status_now = {
		supply_fail_flag_ff,
		ulf_ff,
		olf_ff,
		drv_ff,
		thermal_warning_s
	};

	assign driver_on_out                   = drv_ff;
	assign overvoltage_shutdown_enable_out = ov_shut_en;
	assign underload_shutdown_enable_out   = ul_shut_en;
	assign overcurrent_shutdown_enable_out = oc_shut_en;
endmodule // hbsc_drive_ctrl

/* File: core/hbsc_pkg.sv */
// Package with shared constants and types of the half-bridge serial control port.
// How it works
// - Words are 16 bits, least significant bit first, in and out.
// - Serial input is sampled on each falling serial clock edge.
// - Received word reaches the control register only after chip select rises.
// - Serial output is driven only while chip select is low.
// - A frame applies only when its falling-edge count is a nonzero multiple of 16.
// - The current status word shifts out while the command shifts in.
// - Shift path forwards earlier input bits after 16 clocks for daisy chains.
// - Command bit 15 enables the overvoltage shutdown.
// - Command bit 14 enables the under-load shutdown.
// - Command bit 13 enables the over-current shutdown.
// - Command bits 1 to 12 switch low and high side drivers.
// - Command bit 0 set clears latched faults; clear leaves them alone.
// - Status bit 15 reports a recorded supply fault.
// - Status bit 14 reports a recorded under-load fault.
// - Status bit 13 reports a recorded over-load fault.
// - Status bits 1 to 12 report the real driver states.
// - Fault flags and shutdown latches hold until a status clear command.
// - Over-current with its shutdown disabled only sets the flag.
// - Long under-load switches the driver off only when its shutdown is enabled.
// - Overvoltage lockout forces drivers off, keeps and later resumes programmed states.
package hbsc_pkg;
	localparam int unsigned WORD_W         = 16;
	localparam int unsigned DRV_N          = 12;
	localparam int unsigned CNT_W          = 4;
	localparam int unsigned UL_CNT_W       = 14;
	localparam int unsigned BIT_OV_SHUT_EN = 15;
	localparam int unsigned BIT_UL_SHUT_EN = 14;
	localparam int unsigned BIT_OC_SHUT_EN = 13;
	localparam int unsigned BIT_DRV_HI     = 12;
	localparam int unsigned BIT_DRV_LO     = 1;
	localparam int unsigned BIT_CLEAR      = 0;
	localparam int unsigned SYS_CLK_NS     = 25;
	localparam int unsigned CS_HIGH_MIN_NS = 200;
	localparam int unsigned CS_HIGH_MIN_CYC = (CS_HIGH_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int unsigned UL_DELAY_US    = 200;
	localparam int unsigned UL_DELAY_CYC   = (UL_DELAY_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
	typedef logic [WORD_W-1:0]   hbsc_word_t;
	typedef logic [DRV_N-1:0]    hbsc_drv_t;
	typedef logic [CNT_W-1:0]    hbsc_cnt_t;
	typedef logic [UL_CNT_W-1:0] hbsc_ulcnt_t;
	localparam hbsc_word_t CTRL_RST = 16'h0000;
	localparam hbsc_word_t STAT_RST = 16'h0000;
	localparam hbsc_drv_t  DRV_OFF  = 12'h000;
	localparam hbsc_cnt_t  CNT_ZERO = 4'h0;
	localparam hbsc_cnt_t  CNT_ONE  = 4'h1;
	localparam hbsc_cnt_t  CNT_LAST = 4'hf;
	typedef enum logic [1:0] {
		HBSC_IDLE,
		HBSC_FRAME,
		HBSC_APPLY
	} hbsc_frame_st_t;
endpackage

/* File: core/hbsc_link_if.sv */
// Interface carrying the frame results and status word between the two clock domains.
`timescale 1ns/1ps
interface hbsc_link_if;
	hbsc_pkg::hbsc_word_t rx_word;
	hbsc_pkg::hbsc_cnt_t  edge_cnt;
	logic                 wrapped;
	hbsc_pkg::hbsc_word_t status_word;
	modport link (output rx_word, output edge_cnt, output wrapped, input status_word);
	modport core (input rx_word, input edge_cnt, input wrapped, output status_word);
endinterface

/* File: core/hbsc_sync.sv */
// Two-flop synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
module hbsc_sync #(
	parameter int unsigned W     = 1,
	parameter logic [W-1:0] RST_V = '0
) (
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_ff <= RST_V;
			sync_ff <= RST_V;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule // hbsc_sync

/* File: core/hbsc_spi_link.sv */
// Serial-clock-domain shifter: samples input, counts edges, shifts status out.
`timescale 1ns/1ps
module hbsc_spi_link (
	input  wire logic spi_sclk_in,
	input  wire logic rst_b_in,
	input  wire logic chip_select_n_in,
	input  wire logic serial_data_in,
	output logic      so_data_out,
	hbsc_link_if.link lnk
);
	hbsc_pkg::hbsc_word_t rx_ff;
	hbsc_pkg::hbsc_word_t nxt_rx;
	hbsc_pkg::hbsc_cnt_t  cnt_ff;
	hbsc_pkg::hbsc_cnt_t  nxt_cnt;
	logic                 wrap_ff;
	logic                 nxt_wrap;
	logic                 si_bit_ff;
	logic                 fresh_ff;
	hbsc_pkg::hbsc_word_t tx_ff;
	hbsc_pkg::hbsc_word_t nxt_tx;
	logic                 loaded_ff;
	hbsc_pkg::hbsc_word_t tx_src;
	logic                 had_edge_ff;
	logic                 nxt_had_edge;

	always_comb begin
		nxt_rx = {serial_data_in, rx_ff[hbsc_pkg::WORD_W-1:1]};
		if (fresh_ff) begin
			nxt_cnt  = hbsc_pkg::CNT_ONE;
			nxt_wrap = 1'b0;
		end else begin
			nxt_cnt  = hbsc_pkg::hbsc_cnt_t'(cnt_ff + hbsc_pkg::CNT_ONE);
			nxt_wrap = wrap_ff | (cnt_ff == hbsc_pkg::CNT_LAST);
		end
	end

	// Falling edges sample the input and count the frame length.
	always_ff @(negedge spi_sclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_ff     <= hbsc_pkg::CTRL_RST;
			cnt_ff    <= hbsc_pkg::CNT_ZERO;
			wrap_ff   <= 1'b0;
			si_bit_ff <= 1'b0;
		end else begin
			rx_ff     <= nxt_rx;
			cnt_ff    <= nxt_cnt;
			wrap_ff   <= nxt_wrap;
			si_bit_ff <= serial_data_in;
		end
	end

	// The serial clock stops between frames, so frame start is marked by chip select itself.
	always_ff @(negedge spi_sclk_in or posedge chip_select_n_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fresh_ff <= 1'b1;
		end else if (chip_select_n_in) begin
			fresh_ff <= 1'b1;
		end else begin
			fresh_ff <= 1'b0;
		end
	end

	// Taken at the chip select rise from the value the frame-start flag had just before it is set again.
	// Without it a frame with no clock edge at all would reuse the counts of the frame before.
	always_comb begin
		nxt_had_edge = !fresh_ff;
	end

	always_ff @(posedge chip_select_n_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			had_edge_ff <= 1'b0;
		end else begin
			had_edge_ff <= nxt_had_edge;
		end
	end

	always_comb begin
		tx_src = loaded_ff ? tx_ff : lnk.status_word;
		nxt_tx = {si_bit_ff, tx_src[hbsc_pkg::WORD_W-1:1]};
	end

	always_ff @(posedge spi_sclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_ff <= hbsc_pkg::STAT_RST;
		end else if (!fresh_ff) begin
			tx_ff <= nxt_tx;
		end
	end

	always_ff @(posedge spi_sclk_in or posedge chip_select_n_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			loaded_ff <= 1'b0;
		end else if (chip_select_n_in) begin
			loaded_ff <= 1'b0;
		end else if (!fresh_ff) begin
			loaded_ff <= 1'b1;
		end
	end

	assign so_data_out  = loaded_ff ? tx_ff[0] : lnk.status_word[0];
	assign lnk.rx_word  = rx_ff;
	assign lnk.edge_cnt = cnt_ff;
	assign lnk.wrapped  = wrap_ff && had_edge_ff;
endmodule // hbsc_spi_link

/* File: tb/hbsc_spi_host.sv */
// Host model that clocks frames into the serial control port.
`timescale 1ns/1ps
module hbsc_spi_host (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      si_out,
	input  wire logic so_in
);
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end
	// The clock idles low and runs only inside a frame, so the first edge is a rise.
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		cs_n_out = 1'b0;
		#100;
		for (int k = 0; k < n; k++) begin
			#16 si_out = tx[k];
			#16 sclk_out = 1'b1;
			#32 rx[k] = so_in;
			sclk_out = 1'b0;
		end
		#100 cs_n_out = 1'b1;
		// The input has a pull-down, so a released line reads low.
		si_out = 1'b0;
		#250;
	endtask
endmodule // hbsc_spi_host

/* File: tb/hbsc_drive_ctrl_props.sv */
// Assertions on the ports of the half-bridge serial control port.
`timescale 1ns/1ps
module hbsc_drive_ctrl_props #(
	parameter int unsigned UL_DELAY_CYC = hbsc_pkg::UL_DELAY_CYC
) (
	input wire logic                sys_clk_in,
	input wire logic                rst_b_in,
	input wire logic                spi_sclk_in,
	input wire logic                chip_select_n_in,
	input wire logic                serial_data_in,
	input wire logic                serial_data_out,
	input wire logic                serial_data_oe_out,
	input wire logic                overvoltage_in,
	input wire logic                undervoltage_lockout_in,
	input wire logic                thermal_warning_in,
	input wire hbsc_pkg::hbsc_drv_t overcurrent_in,
	input wire hbsc_pkg::hbsc_drv_t underload_in,
	input wire hbsc_pkg::hbsc_drv_t driver_on_out,
	input wire logic                overvoltage_shutdown_enable_out,
	input wire logic                underload_shutdown_enable_out,
	input wire logic                overcurrent_shutdown_enable_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Counts cycles in which driver index 3 stays on under load with its shutdown enabled.
	int unsigned ul_run_ff;
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ul_run_ff <= 32'h0;
		end else if (underload_shutdown_enable_out && underload_in[3] && driver_on_out[3]) begin
			ul_run_ff <= ul_run_ff + 32'h1;
		end else begin
			ul_run_ff <= 32'h0;
		end
	end
	// Eight quiet cycles cover the apply delay after chip select rises.
	sequence s_quiet;
		(chip_select_n_in && !overvoltage_in && !undervoltage_lockout_in) [*8];
	endsequence
	sequence s_ov_on;
		(overvoltage_shutdown_enable_out && overvoltage_in) [*4];
	endsequence
	a_oe_follows_cs: assert property (
		serial_data_oe_out == !chip_select_n_in) else $error("Output enable differs from chip select.");
	a_ctrl_frozen_low: assert property (
		!chip_select_n_in && $past(chip_select_n_in) == 1'b0 |-> $stable({overvoltage_shutdown_enable_out,
		underload_shutdown_enable_out, overcurrent_shutdown_enable_out})) else $error("Control changed in frame.");
	a_ov_en_after_rise: assert property (
		$changed(overvoltage_shutdown_enable_out) |-> chip_select_n_in && $past(chip_select_n_in, 2))
		else $error("Overvoltage enable changed early.");
	a_ul_en_after_rise: assert property (
		$changed(underload_shutdown_enable_out) |-> $past(chip_select_n_in) && $past(chip_select_n_in, 2))
		else $error("Under-load enable changed early.");
	a_ov_drivers_off: assert property (
		s_ov_on |-> driver_on_out == '0) else $error("Drivers on during overvoltage.");
	a_uv_drivers_off: assert property (
		undervoltage_lockout_in [*4] |-> driver_on_out == '0) else $error("Drivers on during undervoltage.");
	a_oc_latch_off: assert property (
		(overcurrent_shutdown_enable_out && overcurrent_in[1]) [*5] |-> ##[0:4] !driver_on_out[1])
		else $error("Over-current did not switch the driver off.");
	a_ul_latch_off: assert property (
		ul_run_ff == UL_DELAY_CYC + 3 |-> ##[0:3] !driver_on_out[3])
		else $error("Under-load did not switch the driver off.");
	a_quiet_drv_stable: assert property (
		s_quiet ##0 (!overcurrent_shutdown_enable_out && !underload_shutdown_enable_out) |-> $stable(driver_on_out))
		else $error("Drivers changed without cause.");
endmodule // hbsc_drive_ctrl_props
bind hbsc_drive_ctrl hbsc_drive_ctrl_props #(
	.UL_DELAY_CYC (UL_DELAY_CYC)
) i_props (
	.sys_clk_in                      (sys_clk_in),
	.rst_b_in                        (rst_b_in),
	.spi_sclk_in                     (spi_sclk_in),
	.chip_select_n_in                (chip_select_n_in),
	.serial_data_in                  (serial_data_in),
	.serial_data_out                 (serial_data_out),
	.serial_data_oe_out              (serial_data_oe_out),
	.overvoltage_in                  (overvoltage_in),
	.undervoltage_lockout_in         (undervoltage_lockout_in),
	.thermal_warning_in              (thermal_warning_in),
	.overcurrent_in                  (overcurrent_in),
	.underload_in                    (underload_in),
	.driver_on_out                   (driver_on_out),
	.overvoltage_shutdown_enable_out (overvoltage_shutdown_enable_out),
	.underload_shutdown_enable_out   (underload_shutdown_enable_out),
	.overcurrent_shutdown_enable_out (overcurrent_shutdown_enable_out)
);

/* File: tb/hbsc_drive_ctrl_tb.sv */
// Self-checking bench for the half-bridge serial control port.
`timescale 1ns/1ps
module hbsc_drive_ctrl_tb;
	localparam int unsigned UL_CYC = 20;
	logic                 clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 ov = 1'b0;
	logic                 uv = 1'b0;
	logic                 therm = 1'b0;
	hbsc_pkg::hbsc_drv_t  oc = '0;
	hbsc_pkg::hbsc_drv_t  ul = '0;
	hbsc_pkg::hbsc_drv_t  drv;
	logic                 sclk, cs_n, si, so, oe, en_ov, en_ul, en_oc;
	logic [31:0]          rx;
	int                   bad[3] = '{0, 8, 17};
	int                   err_count = 0;
	int                   num_checks = 0;
	wire                  so_w = oe ? so : 1'bz;
	wire hbsc_pkg::hbsc_word_t ctl = {en_ov, en_ul, en_oc, drv, 1'b0};
	always #12.5 clk = ~clk;
	hbsc_spi_host i_host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so_w));
	hbsc_drive_ctrl #(.UL_DELAY_CYC(UL_CYC)) i_dut (
		.sys_clk_in(clk), .rst_b_in(rst_b), .spi_sclk_in(sclk), .chip_select_n_in(cs_n),
		.serial_data_in(si), .serial_data_out(so), .serial_data_oe_out(oe),
		.overvoltage_in(ov), .undervoltage_lockout_in(uv), .thermal_warning_in(therm),
		.overcurrent_in(oc), .underload_in(ul), .driver_on_out(drv),
		.overvoltage_shutdown_enable_out(en_ov), .underload_shutdown_enable_out(en_ul),
		.overcurrent_shutdown_enable_out(en_oc));
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input hbsc_pkg::hbsc_word_t got, input hbsc_pkg::hbsc_word_t exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic fr(input logic [31:0] tx, input int n);
		i_host.xfer(tx, n, rx);
		cyc(2);
	endtask
	task automatic rd(input hbsc_pkg::hbsc_word_t cmd, input hbsc_pkg::hbsc_word_t exp);
		fr({16'h0000, cmd}, 16);
		chk(rx[15:0], exp);
	endtask
	initial begin
		#200000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		cyc(10);
		rst_b = 1'b1;
		cyc(3);
		chk(ctl, 16'h0000);
		fr(32'h0aaa, 16);
		chk(ctl, 16'h0aaa);
		therm = 1'b1;
		cyc(4);
		foreach (bad[i]) begin
			fr(32'h1555, bad[i]);
			chk(ctl, 16'h0aaa);
		end
		fr({16'h1555, 16'h2c3d}, 32);
		chk(rx[15:0], 16'h0aab);
		chk(rx[31:16], 16'h2c3d);
		chk(ctl, 16'h1554);
		therm = 1'b0;
		oc[1] = 1'b1;
		cyc(10);
		oc[1] = 1'b0;
		cyc(4);
		fr(32'h0000, 0);
		chk(ctl, 16'h1554);
		rd(16'h1554, 16'h3554);
		rd(16'h1555, 16'h3554);
		rd(16'h3554, 16'h1554);
		chk(ctl, 16'h3554);
		oc[1] = 1'b1;
		cyc(10);
		oc[1] = 1'b0;
		cyc(4);
		chk(ctl, 16'h3550);
		rd(16'h3554, 16'h3550);
		chk(ctl, 16'h3550);
		rd(16'h5555, 16'h3550);
		chk(ctl, 16'h5554);
		ul[3] = 1'b1;
		cyc(UL_CYC + 10);
		ul[3] = 1'b0;
		cyc(4);
		chk(ctl, 16'h5544);
		rd(16'h9555, 16'h5544);
		chk(ctl, 16'h9554);
		uv = 1'b1;
		cyc(6);
		chk(ctl, 16'h8000);
		uv = 1'b0;
		cyc(6);
		ov = 1'b1;
		cyc(6);
		chk(ctl, 16'h8000);
		ov = 1'b0;
		cyc(6);
		chk(ctl, 16'h9554);
		rd(16'h0000, 16'h9554);
		chk(ctl, 16'h0000);
		tally_and_finish();
	end
endmodule // hbsc_drive_ctrl_tb
